// ---- include/asp_if.sv ----
// register port, sampling pulse and packet stream between the two ends
`timescale 1ns/100ps
interface asp_if (
  input wire logic clk,
  input wire logic resetn
);
  logic        reg_req;
  logic        reg_we;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_ack;
  logic [31:0] reg_rdata;
  logic        smp_tick;
  logic        pk_valid;
  logic        pk_ready;
  logic [7:0]  pk_data;
  logic        pk_end;
  logic [23:0] pk_dest;
  modport dev  (input clk, resetn, reg_req, reg_we, reg_addr, reg_wdata, smp_tick, pk_ready,
                output reg_ack, reg_rdata, pk_valid, pk_data, pk_end, pk_dest);
  modport host (input clk, resetn, reg_ack, reg_rdata, pk_valid, pk_data, pk_end, pk_dest,
                output reg_req, reg_we, reg_addr, reg_wdata, smp_tick, pk_ready);
endinterface

// ---- include/asp_pkg.sv ----
// shared constants for the sample packetizer ends
package asp_pkg;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          NPINS         = 4;
  localparam int          RES_BITS      = 12;
  localparam logic [7:0]  OFF_PIN0      = 8'h00;
  localparam logic [7:0]  OFF_PIN_STEP  = 8'h04;
  localparam logic [7:0]  OFF_GEN       = 8'h20;
  localparam int          PIN_EN_BIT    = 0;
  localparam int          PIN_DEST_LSB  = 8;
  localparam int          GEN_EN_BIT    = 0;
  localparam int          GEN_CAL_BIT   = 1;
  localparam int          GEN_SPP_LSB   = 8;
  localparam int          GEN_WID_LSB   = 16;
  localparam int          GEN_DROP_BIT  = 24;
  localparam logic [1:0]  WID_RST       = 2'h1;
  localparam logic [7:0]  SPP_RST       = 8'h01;
  localparam logic        DROP_RST      = 1'b1;
  localparam logic [1:0]  WID_8         = 2'h0;
  localparam logic [1:0]  WID_16        = 2'h1;
  localparam logic [1:0]  WID_32        = 2'h3;
  localparam logic [2:0]  CAL_PULSES    = 3'h6;
  localparam logic [19:0] CAL_REF_UV    = 20'hc3500;
  localparam int          PULSE_HI_NS   = 200;
  localparam int          PULSE_HI_CYC  = (PULSE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- tb/adc_sample_packetizer_control_test.sv ----
// bench joining both packetizer ends and driving their user sides
`timescale 1ns/100ps
module adc_sample_packetizer_control_test;
  import asp_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_we = 1'b0;
  logic [7:0]  cmd_addr = 8'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic        pulse_req = 1'b0;
  logic        smp_ready = 1'b1;
  logic        conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  wire         cmd_ready, rsp_valid, rsp_err, cal_busy, smp_valid, pkt_end, scale_valid, conv_start, conv_ref_sel;
  wire  [31:0] rsp_rdata, smp_word, cal_scale;
  wire  [23:0] smp_dest;
  wire  [1:0]  conv_pin;
  int          err_count = 0, checked = 0, n_conv = 0, n_end = 0, n0 = 0;
  logic [1:0]  exp_pin = 2'h0, wid = WID_16;
  logic        gen_en = 1'b0, e;
  logic [3:0]  pin_en = 4'h0;
  logic [31:0] q;
  logic [55:0] exp_q[$], rcv_q[$];
  logic [23:0] dest[4] = '{24'h1a2b3c, 24'h0f0f0f, 24'h2c3d4e, 24'h3e4f50};
  logic [1:0]  wlist[3] = '{WID_16, WID_8, WID_32};
  asp_if i_asp_if (.clk(clk), .resetn(resetn));
  asp_dev i_asp_dev (.bus(i_asp_if), .conv_start(conv_start), .conv_pin(conv_pin), .conv_ref_sel(conv_ref_sel),
    .conv_done(conv_done), .conv_result(conv_result));
  asp_host i_asp_host (.bus(i_asp_if), .cmd_valid(cmd_valid), .cmd_we(cmd_we), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .pulse_req(pulse_req), .cal_busy(cal_busy), .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_word(smp_word),
    .smp_dest(smp_dest), .pkt_end(pkt_end), .cal_scale(cal_scale), .scale_valid(scale_valid));
  asp_checker i_asp_checker (.clk(clk), .resetn(resetn), .reg_req(i_asp_if.reg_req), .reg_we(i_asp_if.reg_we),
    .reg_addr(i_asp_if.reg_addr), .reg_wdata(i_asp_if.reg_wdata), .reg_ack(i_asp_if.reg_ack),
    .reg_rdata(i_asp_if.reg_rdata), .smp_tick(i_asp_if.smp_tick), .pk_valid(i_asp_if.pk_valid),
    .pk_ready(i_asp_if.pk_ready), .pk_data(i_asp_if.pk_data), .pk_end(i_asp_if.pk_end), .pk_dest(i_asp_if.pk_dest));
  // free-running clock
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  function automatic logic [31:0] mask(input logic [1:0] w);
    return w == WID_8 ? 32'hff00_0000 : w == WID_16 ? 32'hffff_0000 : 32'hffff_ffff;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one command through the controlling end; the bench keeps its own view of enables and width
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_we = we;
    cmd_addr = a;
    cmd_wdata = d;
    if (we && a == OFF_GEN) begin
      if (d[0] && !gen_en) n_conv = 0;
      gen_en = d[0];
      wid = d[17:16];
    end
    if (we && a < OFF_GEN && !gen_en) pin_en[a[3:2]] = d[0];
    #1;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    q = rsp_rdata;
    e = rsp_err;
    if (n >= 100) chk(0, 1, "no response");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk(q, x, "register read");
  endtask
  // each request spaced past the high and low halves of the tick plus a conversion
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk);
      #1 pulse_req = 1'b1;
      @(posedge clk);
      #1 pulse_req = 1'b0;
      repeat (16) @(posedge clk);
    end
  endtask
  task automatic cmp(input int ends);
    repeat (20) @(posedge clk);
    #1;
    chk(n_end - n0, ends, "packet ends");
    chk(rcv_q.size(), exp_q.size(), "sample count");
    foreach (exp_q[i]) if (i < rcv_q.size()) chk(rcv_q[i], exp_q[i], "sample");
    exp_q.delete();
    rcv_q.delete();
  endtask
  // converter stand-in: answers one cycle after a start and predicts what the sink must get
  always @(posedge clk) begin
    #1;
    if (conv_start === 1'b1) begin
      chk(conv_pin, exp_pin, "pin order");
      n_conv++;
      conv_result = 12'h4b1 + 12'(n_conv * 211);
      if (n_conv > 6 && pin_en[exp_pin]) exp_q.push_back({dest[exp_pin], {conv_result, 20'h0} & mask(wid)});
      exp_pin++;
      @(posedge clk);
      #1 conv_done = 1'b1;
      @(posedge clk);
      #1 conv_done = 1'b0;
    end
  end
  // sink side taken at the falling edge, where handshakes are settled
  always @(negedge clk) begin
    if (smp_valid === 1'b1 && smp_ready === 1'b1) rcv_q.push_back({smp_dest, smp_word});
    if (pkt_end === 1'b1) n_end++;
  end
  // a hang counts as a mismatch and ends the run the usual way
  initial begin
    #(CLK_PERIOD_NS * 30000);
    err_count++;
    $display("CHECK FAILED at %0t: run too long", $time);
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    rd(OFF_GEN, 32'h0101_0100);
    rd(OFF_GEN, 32'h0001_0100);
    rd(8'h30, 32'h0);
    for (int i = 0; i < NPINS; i++) acc(1'b1, OFF_PIN0 + 8'(i) * OFF_PIN_STEP, {dest[i], 7'h0, i != 1});
    rd(OFF_PIN0 + OFF_PIN_STEP * 2, {dest[2], 8'h01});
    acc(1'b1, OFF_GEN, 32'h0001_0101);
    repeat (5) @(posedge clk);
    #1;
    while (cal_busy !== 1'b0 && n0 < 300) begin
      @(posedge clk);
      #1;
      n0++;
    end
    repeat (20) @(posedge clk);
    chk(n_conv, 6, "calibration pulses");
    chk(rcv_q.size(), 0, "quiet calibration");
    foreach (wlist[k]) begin
      acc(1'b1, OFF_GEN, {14'h0, wlist[k], 16'h0101});
      n0 = n_end;
      pulse(4);
      cmp(3);
    end
    acc(1'b1, OFF_GEN, 32'h0001_0201);
    n0 = n_end;
    pulse(8);
    cmp(3);
    acc(1'b1, OFF_GEN, 32'h0001_0001);
    n0 = n_end;
    pulse(4);
    repeat (20) @(posedge clk);
    chk(n_end - n0, 0, "open packet");
    rd(OFF_GEN, 32'h0001_0001);
    cmp(1);
    acc(1'b1, OFF_PIN0 + OFF_PIN_STEP, 32'hffff_ff01);
    chk(e, 1'b1, "pin write refused");
    rd(OFF_PIN0 + OFF_PIN_STEP, {dest[1], 8'h00});
    acc(1'b1, OFF_GEN, 32'h0001_0103);
    chk(conv_ref_sel, 1'b1, "reference select");
    pulse(4);
    repeat (60) @(posedge clk);
    chk(rcv_q.size() + 1, exp_q.size(), "one sample discarded");
    chk(cal_scale, 32'(800000 / exp_q[$][31:20]), "scale factor");
    chk(scale_valid, 1'b1, "scale valid");
    exp_q.delete();
    rcv_q.delete();
    #1 smp_ready = 1'b0;
    pulse(8);
    acc(1'b0, OFF_GEN, 32'h0);
    chk(q[GEN_DROP_BIT], 1'b1, "dropped flag");
    smp_ready = 1'b1;
    repeat (300) @(posedge clk);
    end_sim;
  end
endmodule

// ---- tb/asp_checker.sv ----
// assertions on the link between the converter end and the controlling end
`timescale 1ns/100ps
module asp_checker
  import asp_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        reg_req,
  input wire logic        reg_we,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic [31:0] reg_rdata,
  input wire logic        smp_tick,
  input wire logic        pk_valid,
  input wire logic        pk_ready,
  input wire logic [7:0]  pk_data,
  input wire logic        pk_end,
  input wire logic [23:0] pk_dest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic       gen_rd_q;
  logic       pin_rd_q;
  logic       en_q;
  logic       tick_q;
  logic [2:0] ticks_q;
  // decode of reads and of sampling edges seen while enabled; the count saturates at seven
  wire rd_req   = reg_req && !reg_we;
  wire gen_wr   = reg_req && reg_we && reg_addr == OFF_GEN;
  wire en_rise  = gen_wr && reg_wdata[GEN_EN_BIT] && !en_q;
  wire tick_new = en_q && smp_tick && !tick_q && ticks_q != 3'h7;
  // only a 0 to 1 enable restarts the count, a rewrite while enabled keeps it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gen_rd_q <= 1'b0;
      pin_rd_q <= 1'b0;
      en_q     <= 1'b0;
      tick_q   <= 1'b0;
      ticks_q  <= 3'h0;
    end else begin
      gen_rd_q <= rd_req && reg_addr == OFF_GEN;
      pin_rd_q <= rd_req && reg_addr < OFF_GEN;
      tick_q   <= smp_tick;
      if (gen_wr) en_q <= reg_wdata[GEN_EN_BIT];
      if (en_rise) ticks_q <= 3'h0;
      else if (tick_new) ticks_q <= ticks_q + 3'h1;
    end
  end
  a_ack_after_req: assert property (reg_req |=> reg_ack)
    else $error("register ack missing one cycle after request");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_req))
    else $error("register ack without request");
  a_ack_one_cycle: assert property (reg_ack |=> !reg_ack)
    else $error("register ack longer than one cycle");
  a_rdata_holds: assert property ($changed(reg_rdata) |-> reg_ack)
    else $error("read data changed without ack");
  a_beat_holds: assert property (pk_valid && !pk_ready |=> pk_valid && $stable({pk_data, pk_end, pk_dest}))
    else $error("stalled beat not held");
  a_marker_zero: assert property (pk_valid && pk_end |-> pk_data == 8'h00)
    else $error("end marker carries data");
  a_gen_reserved: assert property (reg_ack && gen_rd_q |-> reg_rdata[31:25] == 7'h0 && reg_rdata[7:2] == 6'h0)
    else $error("general reserved bits not zero");
  a_pin_reserved: assert property (reg_ack && pin_rd_q |-> reg_rdata[7:1] == 7'h00)
    else $error("pin word reserved bits not zero");
  a_cal_quiet: assert property (pk_valid && !pk_end |-> ticks_q == 3'h7)
    else $error("sample sent during calibration pulses");
  a_pin_wr_idle: assert property (reg_req && reg_we && reg_addr < OFF_GEN |-> !en_q)
    else $error("pin word written while converter enabled");
  c_marker: cover property (pk_valid && pk_ready && pk_end);
  c_stall: cover property (pk_valid && !pk_ready);
  c_drop_seen: cover property (reg_ack && gen_rd_q && reg_rdata[GEN_DROP_BIT]);
endmodule

// ---- verilog/asp_dev.sv ----
// converter control end: registers, pulse pacing, sample formatting and packetizing
// How it works
// - dropped flag sets on loss, clears on read
// - width 0 sends top eight result bits
// - width 1 sends sixteen bits, MSB first
// - width 3 sends thirty-two bits, MSB first
// - close packet at programmed sample count
// - count zero closes packet on register access
// - calibration bit selects internal reference
// - software discards one sample after switch
// - software scales readings by 800000 over x
// - pin registers read-only while converter enabled
// - software programs pins only while disabled
// - first six pulses after enable send nothing
// - seventh pulse onward delivers samples
// - controller repeats six pulses each enable
// - converter results are twelve bits wide
// - each pulse rising edge converts next pin
// - pin word holds destination and enable
`timescale 1ns/100ps
module asp_dev #(
  parameter int RES_W = asp_pkg::RES_BITS
) (
  asp_if.dev               bus,
  output logic             conv_start,
  output logic [1:0]       conv_pin,
  output logic             conv_ref_sel,
  input  wire logic        conv_done,
  input  wire logic [RES_W-1:0] conv_result
);
  import asp_pkg::*;

  localparam int EW = 24 + 32 + 2; // dest, word, byte count - 1

  typedef enum logic [2:0] {
    ASP_S_IDLE = 3'b001,
    ASP_S_BYTE = 3'b010,
    ASP_S_END  = 3'b100
  } asp_state_e;

  logic [23:0]     pin_dest_q [NPINS];
  logic [NPINS-1:0] pin_en_q;
  logic            en_q, cal_q, drop_q, ack_q, tick_q, keep_q, start_q, close_q;
  logic [1:0]      wid_q, pin_idx_q, cpin_q, bidx_q, blast_q;
  logic [7:0]      spp_q, pk_cnt_q;
  logic [2:0]      cal_cnt_q;
  logic [31:0]     rdata_q, sh_word_q;
  logic [23:0]     sh_dest_q;
  logic [EW-1:0]   fifo_q [2];
  logic            wr_ptr_q, rd_ptr_q;
  logic [1:0]      fcnt_q;
  asp_state_e      st_q, st_d;

  // register decode
  wire        rd_gen   = bus.reg_req & ~bus.reg_we & (bus.reg_addr == OFF_GEN);
  wire        wr_gen   = bus.reg_req & bus.reg_we & (bus.reg_addr == OFF_GEN);
  wire        gen_en_w = bus.reg_wdata[GEN_EN_BIT];
  logic [NPINS-1:0] pin_hit;
  logic [31:0]      pin_word [NPINS];
  logic [31:0]      rd_d;

  // per-pin decode and read word
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    assign pin_hit[i]  = bus.reg_req & (bus.reg_addr == OFF_PIN0 + 8'(i) * OFF_PIN_STEP);
    assign pin_word[i] = {pin_dest_q[i], 7'h00, pin_en_q[i]};
    always_ff @(posedge bus.clk) begin
      if (!bus.resetn) begin
        pin_dest_q[i] <= 24'h000000;
        pin_en_q[i]   <= 1'b0;
      end else if (pin_hit[i] & bus.reg_we & ~en_q) begin
        pin_dest_q[i] <= bus.reg_wdata[31:PIN_DEST_LSB];
        pin_en_q[i]   <= bus.reg_wdata[PIN_EN_BIT];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_d = 32'h00000000;
    for (int i = 0; i < NPINS; i++) begin
      if (pin_hit[i]) begin
        rd_d = pin_word[i];
      end
    end
    if (bus.reg_addr == OFF_GEN) begin
      rd_d = {7'h00, drop_q, 6'h00, wid_q, spp_q, 6'h00, cal_q, en_q};
    end
  end

  // pulse edge, pacing and start-up discard
  wire rise      = bus.smp_tick & ~tick_q;
  wire take      = rise & en_q;
  wire en_rise   = wr_gen & gen_en_w & ~en_q;
  wire warmed    = (cal_cnt_q == CAL_PULSES);
  wire buf_full  = (fcnt_q == 2'h2);
  wire push_try  = conv_done & keep_q;
  wire push      = push_try & ~buf_full;
  wire drop_set  = push_try & buf_full;
  wire pop       = (st_q == ASP_S_IDLE) & (fcnt_q != 2'h0) & ~(close_q & pk_cnt_q != 8'h00);
  wire byte_done = (st_q == ASP_S_BYTE) & bus.pk_ready;
  wire last_byte = byte_done & (bidx_q == blast_q);
  wire end_done  = (st_q == ASP_S_END) & bus.pk_ready;
  wire [7:0] pk_cnt_inc = pk_cnt_q + 8'h01;

  // sample formatting: left aligned, top bytes only are sent
  wire [31:0] fmt_word = {conv_result, {(32 - RES_W){1'b0}}};
  logic [1:0] fmt_last;
  always_comb begin
    unique case (wid_q)
      WID_16:  fmt_last = 2'h1;
      WID_32:  fmt_last = 2'h3;
      default: fmt_last = 2'h0;
    endcase
  end

  // general control register and dropped flag
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      en_q   <= 1'b0;
      cal_q  <= 1'b0;
      wid_q  <= WID_RST;
      spp_q  <= SPP_RST;
      drop_q <= DROP_RST;
    end else begin
      if (wr_gen) begin
        en_q  <= gen_en_w;
        cal_q <= bus.reg_wdata[GEN_CAL_BIT];
        wid_q <= bus.reg_wdata[GEN_WID_LSB +: 2];
        spp_q <= bus.reg_wdata[GEN_SPP_LSB +: 8];
      end
      drop_q <= drop_set | (drop_q & ~rd_gen);
    end
  end

  // register answer one cycle after the request
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= bus.reg_req;
      rdata_q <= bus.reg_req ? rd_d : rdata_q;
    end
  end

  // conversion launch on each accepted pulse
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      tick_q    <= 1'b0;
      cal_cnt_q <= 3'h0;
      pin_idx_q <= 2'h0;
      cpin_q    <= 2'h0;
      start_q   <= 1'b0;
      keep_q    <= 1'b0;
    end else begin
      tick_q  <= bus.smp_tick;
      start_q <= take;
      if (en_rise) begin
        cal_cnt_q <= 3'h0;
      end else if (take & ~warmed) begin
        cal_cnt_q <= cal_cnt_q + 3'h1;
      end
      if (take) begin
        cpin_q    <= pin_idx_q;
        pin_idx_q <= pin_idx_q + 2'h1;
        keep_q    <= warmed & pin_en_q[pin_idx_q];
      end else if (conv_done) begin
        keep_q <= 1'b0;
      end
    end
  end

  // two-entry buffer between converter and serializer
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fcnt_q   <= 2'h0;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= {pin_dest_q[cpin_q], fmt_word, fmt_last};
        wr_ptr_q         <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // serializer state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ASP_S_IDLE: begin
        if (close_q & pk_cnt_q != 8'h00) begin
          st_d = ASP_S_END;
        end else if (pop) begin
          st_d = ASP_S_BYTE;
        end
      end
      ASP_S_BYTE: begin
        if (last_byte) begin
          st_d = (spp_q != 8'h00 && pk_cnt_inc == spp_q) ? ASP_S_END : ASP_S_IDLE;
        end
      end
      ASP_S_END: begin
        if (end_done) begin
          st_d = ASP_S_IDLE;
        end
      end
      default: st_d = ASP_S_IDLE;
    endcase
  end

  // any register access asks an open endless packet to close; a new request wins over the clear
  wire close_clr = end_done | ((st_q == ASP_S_IDLE) & (pk_cnt_q == 8'h00));
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      st_q     <= ASP_S_IDLE;
      close_q  <= 1'b0;
      pk_cnt_q <= 8'h00;
      bidx_q   <= 2'h0;
      blast_q  <= 2'h0;
      sh_word_q <= 32'h00000000;
      sh_dest_q <= 24'h000000;
    end else begin
      st_q    <= st_d;
      close_q <= (bus.reg_req & (spp_q == 8'h00)) | (close_q & ~close_clr);
      if (pop) begin
        {sh_dest_q, sh_word_q, blast_q} <= fifo_q[rd_ptr_q];
        bidx_q <= 2'h0;
      end else if (byte_done) begin
        // emptied after the last byte, else a narrow sample leaves its low nibble on the end marker beat
        sh_word_q <= last_byte ? 32'h00000000 : {sh_word_q[23:0], 8'h00}; // msb byte first
        bidx_q    <= bidx_q + 2'h1;
      end
      if (end_done) begin
        pk_cnt_q <= 8'h00;
      end else if (last_byte) begin
        pk_cnt_q <= pk_cnt_inc;
      end
    end
  end

  assign bus.reg_ack   = ack_q;
  assign bus.reg_rdata = rdata_q;
  assign bus.pk_valid  = (st_q != ASP_S_IDLE);
  assign bus.pk_end    = (st_q == ASP_S_END);
  assign bus.pk_data   = sh_word_q[31:24];
  assign bus.pk_dest   = sh_dest_q;
  assign conv_start    = start_q;
  assign conv_pin      = cpin_q;
  assign conv_ref_sel  = cal_q;
endmodule

// ---- verilog/asp_host.sv ----
// controlling end: register commands, pulse generation, sample assembly and scaling
`timescale 1ns/100ps
module asp_host (
  asp_if.host               bus,
  input  wire logic         cmd_valid,
  input  wire logic         cmd_we,
  input  wire logic [7:0]   cmd_addr,
  input  wire logic [31:0]  cmd_wdata,
  output logic              cmd_ready,
  output logic              rsp_valid,
  output logic              rsp_err,
  output logic [31:0]       rsp_rdata,
  input  wire logic         pulse_req,
  output logic              cal_busy,
  output logic              smp_valid,
  input  wire logic         smp_ready,
  output logic [31:0]       smp_word,
  output logic [23:0]       smp_dest,
  output logic              pkt_end,
  output logic [31:0]       cal_scale,
  output logic              scale_valid
);
  import asp_pkg::*;

  logic        wait_q, req_q, we_q, rv_q, err_q, en_q, cal_q, skip_q, tick_q, ppend_q, pe_q, sv_q;
  logic [7:0]  addr_q;
  logic [31:0] wdata_q, rdata_q, word_q;
  logic [1:0]  wid_q, bidx_q;
  logic [2:0]  cal_left_q;
  logic [7:0]  pcnt_q;
  logic [23:0] dest_q;
  logic [19:0] num_q, quo_q;
  logic [12:0] rem_q;
  logic [4:0]  dcnt_q;
  logic        div_q;

  // command acceptance; pin writes while enabled are refused locally
  wire take     = cmd_valid & cmd_ready;
  wire pin_wr   = cmd_we & (cmd_addr < OFF_GEN);
  wire refuse   = take & pin_wr & en_q;
  wire gen_wr   = take & cmd_we & (cmd_addr == OFF_GEN);
  wire new_en   = cmd_wdata[GEN_EN_BIT];
  wire new_cal  = cmd_wdata[GEN_CAL_BIT];
  wire [1:0] nb_last = (wid_q == WID_32) ? 2'h3 : (wid_q == WID_16) ? 2'h1 : 2'h0;
  wire byte_in  = bus.pk_valid & bus.pk_ready & ~bus.pk_end;
  wire smp_full = byte_in & (bidx_q == nb_last);
  wire [12:0] rem_sh = {rem_q[11:0], num_q[19]};
  wire [12:0] xdiv   = {1'b0, word_q[31:20]};

  assign cmd_ready = ~wait_q & ~rv_q & ~err_q;

  // register transaction and local shadow of the general control word
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      wait_q <= 1'b0;
      req_q  <= 1'b0;
      we_q   <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      rv_q   <= 1'b0;
      err_q  <= 1'b0;
      en_q   <= 1'b0;
      cal_q  <= 1'b0;
      wid_q  <= WID_RST;
      skip_q <= 1'b0;
      cal_left_q <= 3'h0;
    end else begin
      req_q <= take & ~refuse;
      rv_q  <= bus.reg_ack;
      err_q <= refuse;
      if (take & ~refuse) begin
        wait_q  <= 1'b1;
        we_q    <= cmd_we;
        addr_q  <= cmd_addr;
        wdata_q <= cmd_wdata;
      end else if (bus.reg_ack) begin
        wait_q  <= 1'b0;
        rdata_q <= bus.reg_rdata;
      end
      if (gen_wr) begin
        en_q  <= new_en;
        cal_q <= new_cal;
        wid_q <= cmd_wdata[GEN_WID_LSB +: 2];
        if (new_en & ~en_q) begin
          cal_left_q <= CAL_PULSES;
        end
      end else if (pcnt_q == 8'(2 * PULSE_HI_CYC - 1) && cal_left_q != 3'h0) begin
        cal_left_q <= cal_left_q - 3'h1;
      end
      if (gen_wr & (new_cal != cal_q)) begin
        skip_q <= 1'b1;
      end else if (smp_full) begin
        skip_q <= 1'b0;
      end
    end
  end

  // pulse generator: high for PULSE_HI_CYC cycles, then low for at least one cycle more than that
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      tick_q  <= 1'b0;
      pcnt_q  <= 8'h00;
      ppend_q <= 1'b0;
    end else begin
      ppend_q <= pulse_req | (ppend_q & ~(pcnt_q == 8'h00 & cal_left_q == 3'h0 & tick_q == 1'b0));
      if (tick_q | pcnt_q != 8'h00) begin
        pcnt_q <= (pcnt_q == 8'(2 * PULSE_HI_CYC - 1)) ? 8'h00 : pcnt_q + 8'h01;
        tick_q <= (pcnt_q < 8'(PULSE_HI_CYC - 1));
      end else if (ppend_q | cal_left_q != 3'h0) begin
        tick_q <= 1'b1;
      end
    end
  end

  // byte assembly into left aligned words; end marker reported as a pulse
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      word_q <= 32'h00000000;
      bidx_q <= 2'h0;
      sv_q   <= 1'b0;
      pe_q   <= 1'b0;
      dest_q <= 24'h000000;
    end else begin
      pe_q <= bus.pk_valid & bus.pk_ready & bus.pk_end;
      if (byte_in) begin
        word_q <= (bidx_q == 2'h0) ? {bus.pk_data, 24'h000000} : (word_q | ({24'h000000, bus.pk_data} <<
                  (5'h18 - {bidx_q, 3'h0})));
        bidx_q <= smp_full ? 2'h0 : bidx_q + 2'h1;
        dest_q <= bus.pk_dest;
      end
      if (smp_full & ~skip_q) begin
        sv_q <= 1'b1;
      end else if (smp_ready) begin
        sv_q <= 1'b0;
      end
    end
  end

  // restoring divider for the reference scale, started by a kept calibration sample
  always_ff @(posedge bus.clk) begin
    if (!bus.resetn) begin
      div_q  <= 1'b0;
      dcnt_q <= 5'h00;
      num_q  <= 20'h00000;
      quo_q  <= 20'h00000;
      rem_q  <= 13'h0000;
      scale_valid <= 1'b0;
    end else if (sv_q & smp_ready & cal_q & ~div_q) begin
      div_q  <= 1'b1;
      dcnt_q <= 5'h00;
      num_q  <= CAL_REF_UV;
      rem_q  <= 13'h0000;
      scale_valid <= 1'b0;
    end else if (div_q) begin
      num_q  <= {num_q[18:0], 1'b0};
      rem_q  <= (rem_sh >= xdiv) ? rem_sh - xdiv : rem_sh;
      quo_q  <= {quo_q[18:0], rem_sh >= xdiv};
      dcnt_q <= dcnt_q + 5'h01;
      if (dcnt_q == 5'h13) begin
        div_q       <= 1'b0;
        scale_valid <= 1'b1;
      end
    end
  end

  assign bus.reg_req   = req_q;
  assign bus.reg_we    = we_q;
  assign bus.reg_addr  = addr_q;
  assign bus.reg_wdata = wdata_q;
  assign bus.smp_tick  = tick_q;
  assign bus.pk_ready  = ~sv_q & ~div_q;
  assign rsp_valid     = rv_q | err_q;
  assign rsp_err       = err_q;
  assign rsp_rdata     = rdata_q;
  assign cal_busy      = (cal_left_q != 3'h0);
  assign smp_valid     = sv_q;
  assign smp_word      = word_q;
  assign smp_dest      = dest_q;
  assign pkt_end       = pe_q;
  assign cal_scale     = {12'h000, quo_q};
endmodule
